// ===== common/tfc4_defs.svh
`ifndef TFC4_DEFS_SVH
`define TFC4_DEFS_SVH
// Register word indices as printed; the byte address is four times the index
`define TFC4_IDX_PINCFG 8'h7d
`define TFC4_IDX_TEST1 8'h7e
`define TFC4_IDX_TEST2 8'h7f
`define TFC4_IDX_CTRL 8'h80
`define TFC4_IDX_STATUS 8'h81
`define TFC4_IDX_MASK 8'h82
`define TFC4_IDX_LIMITS 8'h83
// Field positions of the pin and overtemperature configuration register
`define TFC4_F_PINSEL_LO 0
`define TFC4_F_OTDIS 2
`define TFC4_F_MAXDUTY 3
`define TFC4_F_BYP_LO 4
// Reset values
`define TFC4_RST_PINCFG 8'h00
`define TFC4_RST_TEST 8'h00
// Disable codes of the overtemperature limit
`define TFC4_OFF64_DISABLE 8'h00
`define TFC4_TWOS_DISABLE 8'h80
// Status bits
`define TFC4_ST_OVERTEMP 0
`define TFC4_ST_PINCHG 1
`define TFC4_ST_LOCKWR 2
`endif

// ===== common/tfc4_pkg.sv
package tfc4_pkg;
    typedef enum logic [1:0] {
        TFC4_PIN_FAN4 = 2'h0,
        TFC4_PIN_OVERTEMP = 2'h1,
        TFC4_PIN_ALERT = 2'h2,
        TFC4_PIN_GPIO = 2'h3
    } tfc4_pinsel_t;
    typedef enum logic [1:0] {
        TFC4_FAN_LOOP,
        TFC4_FAN_FULL,
        TFC4_FAN_MAXDUTY
    } tfc4_fanmode_t;
endpackage

// ===== common/tfc4_pin_if.sv
// Pin function selection and the signals routed through the shared pin
interface tfc4_pin_if;
    import tfc4_pkg::*;
    tfc4_pinsel_t sel;
    logic overtempDrive;
    logic alertDrive;
    logic gpioOut;
    logic gpioOe;
    logic padIn;
    logic padOut;
    logic padOe;
    logic fan4Speed;
    logic overtempIn;
    logic gpioIn;
    modport ctrl (output sel, overtempDrive, alertDrive, gpioOut, gpioOe, padIn,
        input padOut, padOe, fan4Speed, overtempIn, gpioIn);
    modport mux (input sel, overtempDrive, alertDrive, gpioOut, gpioOe, padIn,
        output padOut, padOe, fan4Speed, overtempIn, gpioIn);
endinterface

// ===== hdl/tfc4_pin_mux.sv
module tfc4_pin_mux
    import tfc4_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clkEn,
    tfc4_pin_if.mux pin
);
    // Registered routing; unselected inputs see their idle level: overtemp input high, fan4 speed and GPIO input low
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pin.padOut <= 1'b0;
            pin.padOe <= 1'b0;
            pin.fan4Speed <= 1'b0;
            pin.overtempIn <= 1'b1;
            pin.gpioIn <= 1'b0;
        end
        else if (clkEn)
        begin
            pin.fan4Speed <= (pin.sel == TFC4_PIN_FAN4) ? pin.padIn : 1'b0;
            pin.overtempIn <= (pin.sel == TFC4_PIN_OVERTEMP) ? pin.padIn : 1'b1;
            pin.gpioIn <= (pin.sel == TFC4_PIN_GPIO) ? pin.padIn : 1'b0;
            unique case (pin.sel)
                TFC4_PIN_FAN4:
                begin
                    pin.padOut <= 1'b0;
                    pin.padOe <= 1'b0;
                end
                TFC4_PIN_OVERTEMP:
                begin
                    // Open drain, active low: drive only while asserting
                    pin.padOut <= 1'b0;
                    pin.padOe <= pin.overtempDrive;
                end
                TFC4_PIN_ALERT:
                begin
                    pin.padOut <= 1'b0;
                    pin.padOe <= pin.alertDrive;
                end
                TFC4_PIN_GPIO:
                begin
                    pin.padOut <= pin.gpioOut;
                    pin.padOe <= pin.gpioOe;
                end
            endcase
        end
    end
endmodule // tfc4_pin_mux

// ===== hdl/tfc4_config.sv
// Functional notes
// - Selector 00 fan4 speed input, 01 overtemp, 10 bus alert, 11 GPIO.
// - Overtemp output disable set suppresses overtemp output on all channels.
// - Disable clear: overtemp output follows per-channel enables and limits.
// - Offset-64 coding: limit of -64 degrees disables that channel.
// - Twos-complement coding: limit of -128 degrees disables that channel.
// - Max duty bit 0: overtemp drives fans to full speed.
// - Max duty bit 1: overtemp drives fans to programmed maximum duty.
// - Bits 4-7 bypass the four voltage attenuators, full scale 2.25 V.
// - Global lock set makes this register read-only; writes ignored.
// - Configuration register resets to zero: fan4 input, no bypass.
`include "tfc4_defs.svh"
module tfc4_config
    import tfc4_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic globalLock,
    input wire logic twosCompMode,
    input wire logic [2:0] chanOvertempEn,
    input wire logic [2:0] chanOverLimit,
    input wire logic alertRequest,
    input wire logic padIn,
    output logic padOut,
    output logic padOe,
    output logic fan4SpeedInput,
    output logic overtempSignalIn,
    output logic gpioInput,
    output logic overtempAsserted,
    output logic [1:0] fanMode,
    output logic [3:0] bypassAtten,
    output logic irq
);
    logic [7:0] pinCfg_reg;
    logic [7:0] limit_reg [3];
    logic [2:0] status_reg;
    logic [2:0] mask_reg;
    logic gpioOut_reg;
    logic gpioOe_reg;
    logic [1:0] padSync_reg;
    logic lockSync_reg;
    logic [2:0] chanActive;
    logic overtempNow;
    logic overtempPrev_reg;
    logic [31:0] rdata_next;
    logic accessPhase;
    logic writeStrobe;
    logic [9:0] wordIdx;
    logic pinChange;
    logic lockedWrite;
    logic [2:0] statusSet;
    logic statusClr;
    tfc4_pin_if pin();

    // Limit at its disable code turns one channel off
    function automatic logic limitDisables(input logic [7:0] lim, input logic twos);
        limitDisables = twos ? (lim == `TFC4_TWOS_DISABLE) : (lim == `TFC4_OFF64_DISABLE);
    endfunction

    // Word index of the current address; byte offsets within a word ignored
    function automatic logic hit(input logic [9:0] idx, input logic [7:0] reg_idx);
        hit = (idx == {2'h0, reg_idx});
    endfunction

    assign wordIdx = paddr[11:2];
    // Only the first access edge counts: the request still stands in the ready cycle
    assign accessPhase = psel && penable && clkEn && !pready;
    assign writeStrobe = accessPhase && pwrite;

    // Pad input crosses from outside, so two flops before any use
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            padSync_reg <= 2'h3;
        else if (clkEn)
            padSync_reg <= {padSync_reg[0], padIn};
    end

    // Lock comes from same-clock logic; registered once for a clean write gate
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            lockSync_reg <= 1'b0;
        else if (clkEn)
            lockSync_reg <= globalLock;
    end

    assign lockedWrite = writeStrobe && hit(wordIdx, `TFC4_IDX_PINCFG) && (globalLock || lockSync_reg);
    assign pinChange = writeStrobe && hit(wordIdx, `TFC4_IDX_PINCFG) && !lockedWrite
        && (pwdata[1:0] != pinCfg_reg[1:0]);

    // Configuration register; lock blocks writes from the same cycle on
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            pinCfg_reg <= `TFC4_RST_PINCFG;
        else if (writeStrobe && hit(wordIdx, `TFC4_IDX_PINCFG) && !lockedWrite)
            pinCfg_reg <= pwdata[7:0];
    end

    // Channel limits, GPIO control and mask are plain software state
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            limit_reg[0] <= 8'h7f;
            limit_reg[1] <= 8'h7f;
            limit_reg[2] <= 8'h7f;
            gpioOut_reg <= 1'b0;
            gpioOe_reg <= 1'b0;
            mask_reg <= 3'h0;
        end
        else if (writeStrobe)
        begin
            if (hit(wordIdx, `TFC4_IDX_LIMITS))
            begin
                limit_reg[0] <= pwdata[7:0];
                limit_reg[1] <= pwdata[15:8];
                limit_reg[2] <= pwdata[23:16];
            end
            if (hit(wordIdx, `TFC4_IDX_CTRL))
            begin
                gpioOut_reg <= pwdata[0];
                gpioOe_reg <= pwdata[1];
            end
            if (hit(wordIdx, `TFC4_IDX_MASK))
                mask_reg <= pwdata[2:0];
        end
    end

    // Per-channel permission: enable set and limit not at its disable code
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++)
        begin : g_chan
            assign chanActive[ch] = chanOvertempEn[ch] && chanOverLimit[ch]
                && !limitDisables(limit_reg[ch], twosCompMode);
        end
    endgenerate

    assign overtempNow = |chanActive;

    // Overtemp output and fan override; the fan override holds even with
    // the output disabled, since cooling must not depend on the pin
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            overtempAsserted <= 1'b0;
            fanMode <= TFC4_FAN_LOOP;
            overtempPrev_reg <= 1'b0;
        end
        else if (clkEn)
        begin
            overtempAsserted <= overtempNow && !pinCfg_reg[`TFC4_F_OTDIS];
            overtempPrev_reg <= overtempNow;
            if (!overtempNow)
                fanMode <= TFC4_FAN_LOOP;
            else if (pinCfg_reg[`TFC4_F_MAXDUTY])
                fanMode <= TFC4_FAN_MAXDUTY;
            else
                fanMode <= TFC4_FAN_FULL;
        end
    end

    // Attenuator bypass, one bit per rail, straight from the register
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            bypassAtten <= 4'h0;
        else if (clkEn)
            bypassAtten <= pinCfg_reg[`TFC4_F_BYP_LO +: 4];
    end

    // Status events and the write-one clear strobe
    assign statusSet[`TFC4_ST_OVERTEMP] = overtempNow && !overtempPrev_reg;
    assign statusSet[`TFC4_ST_PINCHG] = pinChange;
    assign statusSet[`TFC4_ST_LOCKWR] = lockedWrite;
    assign statusClr = writeStrobe && hit(wordIdx, `TFC4_IDX_STATUS);

    // Sticky status; a new event wins over a write-one clear in the same cycle
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            status_reg <= 3'h0;
        else if (clkEn)
            status_reg <= statusSet | (status_reg & ~(pwdata[2:0] & {3{statusClr}}));
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            irq <= 1'b0;
        else if (clkEn)
            irq <= |(status_reg & mask_reg);
    end

    // Read mux; test registers are constant reserved words
    always_comb
    begin
        rdata_next = 32'h0;
        if (hit(wordIdx, `TFC4_IDX_PINCFG))
            rdata_next = {24'h0, pinCfg_reg};
        else if (hit(wordIdx, `TFC4_IDX_TEST1) || hit(wordIdx, `TFC4_IDX_TEST2))
            rdata_next = {24'h0, `TFC4_RST_TEST};
        else if (hit(wordIdx, `TFC4_IDX_CTRL))
            rdata_next = {29'h0, lockSync_reg, gpioOe_reg, gpioOut_reg};
        else if (hit(wordIdx, `TFC4_IDX_STATUS))
            rdata_next = {29'h0, status_reg};
        else if (hit(wordIdx, `TFC4_IDX_MASK))
            rdata_next = {29'h0, mask_reg};
        else if (hit(wordIdx, `TFC4_IDX_LIMITS))
            rdata_next = {8'h0, limit_reg[2], limit_reg[1], limit_reg[0]};
    end

    // APB answer: one wait state, pready pulses in the second access cycle
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (clkEn)
        begin
            pready <= psel && penable && !pready;
            prdata <= (psel && !pwrite) ? rdata_next : 32'h0;
            pslverr <= psel && penable && !pready && (wordIdx < {2'h0, `TFC4_IDX_PINCFG}
                || wordIdx > {2'h0, `TFC4_IDX_LIMITS});
        end
    end

    assign pin.sel = tfc4_pinsel_t'(pinCfg_reg[`TFC4_F_PINSEL_LO +: 2]);
    assign pin.overtempDrive = overtempNow && !pinCfg_reg[`TFC4_F_OTDIS];
    assign pin.alertDrive = alertRequest || irq;
    assign pin.gpioOut = gpioOut_reg;
    assign pin.gpioOe = gpioOe_reg;
    assign pin.padIn = padSync_reg[1];
    assign padOut = pin.padOut;
    assign padOe = pin.padOe;
    assign fan4SpeedInput = pin.fan4Speed;
    assign overtempSignalIn = pin.overtempIn;
    assign gpioInput = pin.gpioIn;

    tfc4_pin_mux u_mux (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .clkEn(clkEn),
        .pin(pin.mux)
    );
endmodule // tfc4_config

// ===== tb/tfc4_pad_model.sv
// Board side of the shared pin: open drain with a pull-up
module tfc4_pad_model (
    input wire logic padOut,
    input wire logic padOe,
    input wire logic extOe,
    input wire logic extLevel,
    output logic padIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released wire floats up, never to the last driven value
    assign padIn = padOe ? padOut : (extOe ? extLevel : 1'b1);
endmodule // tfc4_pad_model

// ===== tb/tfc4_config_properties.sv
module tfc4_config_properties (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic globalLock,
    input wire logic [1:0] fanMode,
    input wire logic [3:0] bypassAtten,
    input wire logic [2:0] chanOvertempEn,
    input wire logic [2:0] chanOverLimit,
    input wire logic overtempAsserted
);
    timeunit 1ns;
    timeprecision 1ps;
    logic chanHot;
    // Some channel enabled and above its limit; the limit code may still veto it
    assign chanHot = |(chanOvertempEn & chanOverLimit);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // First access edge of a transfer
    sequence accessS;
        psel && penable && clkEn && !pready;
    endsequence
    sequence badIdxS;
        accessS ##0 (paddr[11:2] < 10'h07d || paddr[11:2] > 10'h083);
    endsequence
    sequence goodIdxS;
        accessS ##0 (paddr[11:2] >= 10'h07d && paddr[11:2] <= 10'h083);
    endsequence
    ready_after_access_a: assert property (accessS |=> pready)
        else $error("ready late");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("stray error");
    bad_index_error_a: assert property (badIdxS |=> pslverr && prdata == 32'h0)
        else $error("bad index accepted");
    good_index_ok_a: assert property (goodIdxS |=> !pslverr)
        else $error("good index refused");
    // Locked at the write edge means the attenuator bypass field may not move
    lock_freezes_config_a: assert property ($past(globalLock) |-> $stable(bypassAtten))
        else $error("locked write stored");
    reset_clears_bypass_a: assert property ($rose(rstn) |-> bypassAtten == 4'h0)
        else $error("bypass after reset");
    // Override only after a hot channel, and never with the unused code
    fan_mode_legal_a: assert property (fanMode != 2'h0 |-> fanMode != 2'h3
        && (!$past(clkEn) || $past(chanHot)))
        else $error("fan mode code");
    overtemp_needs_chan_a: assert property (overtempAsserted |-> !$past(clkEn)
        || $past(chanHot))
        else $error("overtemp without hot channel");
endmodule // tfc4_config_properties

// ===== tb/tb_thermal_fan_config_register_four.sv
`include "tfc4_defs.svh"
module tb_thermal_fan_config_register_four;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rstn, psel, penable, pwrite, globalLock, twosCompMode, er, x;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, padIn, padOut, padOe, fan4SpeedInput, overtempSignalIn;
    logic gpioInput, overtempAsserted, irq, alertRequest;
    logic [2:0] chanOvertempEn, chanOverLimit;
    logic [1:0] fanMode;
    logic [3:0] bypassAtten;
    int fails = 0;
    int total_checks = 0;
    tfc4_config dut (.clk_sys(clk_sys), .rstn(rstn), .clkEn(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .globalLock(globalLock),
        .twosCompMode(twosCompMode), .chanOvertempEn(chanOvertempEn),
        .chanOverLimit(chanOverLimit), .alertRequest(alertRequest), .padIn(padIn),
        .padOut(padOut), .padOe(padOe), .fan4SpeedInput(fan4SpeedInput),
        .overtempSignalIn(overtempSignalIn), .gpioInput(gpioInput),
        .overtempAsserted(overtempAsserted), .fanMode(fanMode),
        .bypassAtten(bypassAtten), .irq(irq));
    tfc4_pad_model pad (.padOut(padOut), .padOe(padOe), .extOe(1'b0), .extLevel(1'b0),
        .padIn(padIn));
    // Free-running system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic end_sim;
        if (fails == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; three idle cycles follow so strobes never re-arm in one step
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50)
            fails++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    // Bound on a hang, far beyond the few hundred cycles the tests need
    initial
    begin
        #100000;
        fails++;
        end_sim();
    end
    initial
    begin
        {rstn, psel, penable, pwrite, globalLock, twosCompMode, alertRequest} = 7'h0;
        {paddr, pwdata, chanOvertempEn, chanOverLimit} = 50'h0;
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        apb(0, `TFC4_IDX_PINCFG, 0);
        chk(rd, 32'h0);
        chk(32'({fan4SpeedInput, bypassAtten}), 32'h10);
        apb(1, `TFC4_IDX_PINCFG, 32'ha0);
        apb(0, `TFC4_IDX_PINCFG, 0);
        chk(32'({rd[7:0], bypassAtten}), 32'ha0a);
        apb(1, `TFC4_IDX_CTRL, 32'h3);
        alertRequest <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            apb(1, `TFC4_IDX_PINCFG, 32'(s));
            // Pad level needs the two-flop synchroniser plus the routing flop
            @(posedge clk_sys);
            chk(32'({fan4SpeedInput, overtempSignalIn, gpioInput}), {s == 0, 1'b1, s == 3});
            chk(32'(padOe), 32'(s >= 2));
        end
        alertRequest <= 1'b0;
        apb(1, `TFC4_IDX_PINCFG, 32'h1);
        chanOvertempEn <= 3'h1;
        chanOverLimit <= 3'h1;
        repeat (4) @(posedge clk_sys);
        chk(32'({overtempAsserted, fanMode, padOe, padOut}), 32'h16);
        apb(1, `TFC4_IDX_PINCFG, 32'h5);
        chk(32'({overtempAsserted, fanMode, padOe}), 32'h2);
        apb(1, `TFC4_IDX_PINCFG, 32'h9);
        chk(32'({overtempAsserted, fanMode, padOe}), 32'hd);
        apb(1, `TFC4_IDX_LIMITS, 32'h7f7f00);
        chk(32'({overtempAsserted, padOe}), 32'h0);
        twosCompMode <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(32'({overtempAsserted, padOe}), 32'h3);
        apb(1, `TFC4_IDX_LIMITS, 32'h7f7f80);
        chk(32'({overtempAsserted, padOe}), 32'h0);
        // Interrupt must follow the mask, then drop once status is cleared
        apb(1, `TFC4_IDX_MASK, 32'h0);
        x = irq;
        apb(1, `TFC4_IDX_MASK, 32'h7);
        chk(32'(x ^ irq), 32'h1);
        apb(1, `TFC4_IDX_STATUS, 32'h7);
        apb(0, `TFC4_IDX_STATUS, 0);
        chk(32'({rd[0], irq}), 32'h0);
        globalLock <= 1'b1;
        apb(1, `TFC4_IDX_PINCFG, 32'hff);
        apb(0, `TFC4_IDX_PINCFG, 0);
        chk(rd, 32'h9);
        apb(0, `TFC4_IDX_STATUS, 0);
        chk(32'(rd[2]), 32'h1);
        // The host keeps off the reserved test registers and only reads them
        for (int t = 0; t < 2; t++)
        begin
            apb(0, 8'(`TFC4_IDX_TEST1 + t), 0);
            chk(rd, 32'h0);
        end
        apb(0, 8'h90, 0);
        chk({rd[30:0], er}, 32'h1);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        apb(0, `TFC4_IDX_PINCFG, 0);
        chk(rd, 32'h0);
        end_sim();
    end
endmodule // tb_thermal_fan_config_register_four
bind tfc4_config tfc4_config_properties chk_i (.clk_sys(clk_sys), .rstn(rstn),
    .clkEn(clkEn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .globalLock(globalLock), .fanMode(fanMode),
    .bypassAtten(bypassAtten), .chanOvertempEn(chanOvertempEn),
    .chanOverLimit(chanOverLimit), .overtempAsserted(overtempAsserted));
